// File: src/afr_pkg.sv
package afr_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ = 20_000_000;
	localparam int PWM_IDLE_NS = 13_000;
	// Longest time, so rounded down
	localparam int PWM_IDLE_CYC = (PWM_IDLE_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int PWM_CNT_W = 10;

	// ****************************************
	// Temperature thresholds, degrees C
	// ****************************************
	localparam logic [7:0] WARN_TEMP_C = 8'h73;
	localparam logic [7:0] ERR_TEMP_C = 8'h9B;

	// ****************************************
	// Fault reasons shown on status
	// ****************************************
	typedef struct packed {
		logic undervoltage_fault;
		logic overload_fault;
		logic pwm_idle;
		logic overtemp_error;
	} afr_fault_t;

	typedef enum logic [1:0] {
		AFR_HIZ = 2'b00,
		AFR_RUN = 2'b01,
		AFR_FAULT = 2'b10
	} afr_state_t;

endpackage : afr_pkg

// File: src/afr_fault_report.sv
`timescale 1ns/100ps
module afr_fault_report import afr_pkg::*; #(
	parameter logic [7:0] WARN_C = WARN_TEMP_C,
	parameter int PWM_IDLE = PWM_IDLE_CYC
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic reset_n,
	input wire logic gate_drive_supply,
	input wire logic vdd_supply_ok,
	input wire logic [7:0] junction_temp,
	input wire logic overload_fault,
	input wire logic [1:0] pwm_in,
	output logic stage_enable,
	output logic output_pulldown,
	output logic shutdown_flag_n_o,
	output logic shutdown_flag_n_oe,
	output logic overtemp_warn_n_o,
	output logic overtemp_warn_n_oe,
	output afr_fault_t fault_cause
);

	// ****************************************
	// PWM activity
	// ****************************************
	logic [1:0] pwm_prev_r;
	logic pwm_idle;
	logic [1:0] idle_hit;

	always_ff @(posedge clk) begin
		if (srst) begin
			pwm_prev_r <= 2'h0;
		end else if (clk_en) begin
			pwm_prev_r <= pwm_in;
		end
	end

	for (genvar i = 0; i < 2; i++) begin : g_act
		logic [PWM_CNT_W-1:0] idle_cnt_r;
		always_ff @(posedge clk) begin
			if (srst) begin
				idle_cnt_r <= '0;
			end else if (clk_en) begin
				if (pwm_in[i] != pwm_prev_r[i]) begin
					idle_cnt_r <= '0;
				end else if (!idle_hit[i]) begin
					idle_cnt_r <= idle_cnt_r + 1'b1;
				end
			end
		end
		assign idle_hit[i] = (idle_cnt_r >= PWM_CNT_W'(PWM_IDLE));
	end

	// Any one stuck input shuts the whole stage; not latched
	assign pwm_idle = |idle_hit;

	// ****************************************
	// Latched faults
	// ****************************************
	logic ote_lat_r;
	logic olp_lat_r;
	logic reset_n_r;
	logic ote_now;
	logic uv;

	assign ote_now = junction_temp >= ERR_TEMP_C;
	assign uv = !(gate_drive_supply && vdd_supply_ok);

	always_ff @(posedge clk) begin
		if (srst) begin
			reset_n_r <= 1'b0;
		end else if (clk_en) begin
			reset_n_r <= reset_n;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ote_lat_r <= 1'b0;
			olp_lat_r <= 1'b0;
		end else if (clk_en) begin
			if (!reset_n) begin
				ote_lat_r <= 1'b0;
				olp_lat_r <= 1'b0;
			end else begin
				if (ote_now) begin
					ote_lat_r <= 1'b1;
				end
				// Power-on reset of the overload latch comes with undervoltage
				if (uv && !overload_fault) begin
					olp_lat_r <= 1'b0;
				end else if (overload_fault) begin
					olp_lat_r <= 1'b1;
				end
			end
		end
	end

	// ****************************************
	// Stage control and status
	// ****************************************
	afr_fault_t cause;
	logic shut;
	logic warn;
	afr_state_t state_r;

	always_comb begin
		cause.undervoltage_fault = uv;
		cause.overload_fault = olp_lat_r || overload_fault;
		cause.pwm_idle = pwm_idle;
		cause.overtemp_error = ote_lat_r || ote_now;
	end

	// Non-overload, non-thermal causes drop out with their inputs
	assign shut = |cause;
	assign warn = (junction_temp >= WARN_C) || cause.overtemp_error;

	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= AFR_HIZ;
		end else if (clk_en) begin
			if (!reset_n) begin
				state_r <= AFR_HIZ;
			end else if (shut) begin
				state_r <= AFR_FAULT;
			end else begin
				state_r <= AFR_RUN;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			stage_enable <= 1'b0;
			output_pulldown <= 1'b0;
			shutdown_flag_n_oe <= 1'b0;
			overtemp_warn_n_oe <= 1'b0;
			fault_cause <= '0;
		end else if (clk_en) begin
			stage_enable <= reset_n && !shut;
			output_pulldown <= !reset_n;
			if (!reset_n) begin
				shutdown_flag_n_oe <= 1'b0;
				overtemp_warn_n_oe <= 1'b0;
				fault_cause <= '0;
			end else begin
				shutdown_flag_n_oe <= shut;
				overtemp_warn_n_oe <= warn;
				fault_cause <= cause;
			end
		end
	end

	// Open drain: only ever drives low
	always_ff @(posedge clk) begin
		if (srst) begin
			shutdown_flag_n_o <= 1'b0;
			overtemp_warn_n_o <= 1'b0;
		end else begin
			shutdown_flag_n_o <= 1'b0;
			overtemp_warn_n_o <= 1'b0;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_uv_hiz: assert property (@(posedge clk) disable iff (srst)
		clk_en && uv |=> !stage_enable)
		else $error("stage enabled under undervoltage");
	a_fault_flag: assert property (@(posedge clk) disable iff (srst)
		clk_en && reset_n && shut |=> shutdown_flag_n_oe)
		else $error("shutdown flag not asserted on fault");
	a_reset_release: assert property (@(posedge clk) disable iff (srst)
		clk_en && !reset_n |=> !shutdown_flag_n_oe && !overtemp_warn_n_oe)
		else $error("status held during reset");
	a_warn_only: assert property (@(posedge clk) disable iff (srst)
		clk_en && reset_n && !shut && junction_temp >= WARN_C
		|=> overtemp_warn_n_oe && !shutdown_flag_n_oe)
		else $error("warning encoding wrong");
	a_ote_latch: assert property (@(posedge clk) disable iff (srst)
		clk_en && reset_n && ote_now ##1 clk_en && reset_n |=> !stage_enable)
		else $error("overtemp error not latched");
	a_olp_hold: assert property (@(posedge clk) disable iff (srst)
		clk_en && reset_n && overload_fault ##1 (clk_en && reset_n)[*2]
		|-> ##1 !stage_enable)
		else $error("overload recovered without reset");
	a_pwm_idle: assert property (@(posedge clk) disable iff (srst)
		clk_en && reset_n && pwm_idle |=> !stage_enable && shutdown_flag_n_oe)
		else $error("pwm idle not shut down");
	a_auto_run: assert property (@(posedge clk) disable iff (srst)
		clk_en && reset_n && !shut |=> stage_enable)
		else $error("no automatic recovery");
	a_od_low: assert property (@(posedge clk) disable iff (srst)
		!shutdown_flag_n_o && !overtemp_warn_n_o)
		else $error("open drain drove high");
	a_reset_resume: assert property (@(posedge clk) disable iff (srst)
		clk_en && reset_n && !reset_n_r && !shut |=> stage_enable)
		else $error("no resume after reset release");
	a_state_run: assert property (@(posedge clk) disable iff (srst)
		stage_enable == (state_r == AFR_RUN))
		else $error("stage enable disagrees with state");

	c_ote: cover property (@(posedge clk) disable iff (srst) ote_lat_r ##1 !reset_n);
	c_pwm: cover property (@(posedge clk) disable iff (srst) pwm_idle ##1 !pwm_idle);
	c_warn: cover property (@(posedge clk) disable iff (srst)
		overtemp_warn_n_oe && !shutdown_flag_n_oe);

endmodule : afr_fault_report

// File: dv/afr_ctrl_model.sv
`timescale 1ns/100ps
module afr_ctrl_model (
	input wire logic clk,
	input wire logic pwm_run,
	input wire logic sd_o,
	input wire logic sd_oe,
	input wire logic otw_o,
	input wire logic otw_oe,
	output wire logic [1:0] pwm_in,
	output wire logic sd_pin,
	output wire logic otw_pin
);
	// ****************
	// PWM source
	// ****************
	// Stalling holds both lines, as a dead modulator would
	logic [1:0] ph_r = 2'h1;
	always @(posedge clk) begin
		if (pwm_run) begin
			ph_r <= ~ph_r;
		end
	end
	assign pwm_in = ph_r;
	// Internal pull-up sets the level when nobody pulls low
	assign sd_pin = sd_oe ? sd_o : 1'b1;
	assign otw_pin = otw_oe ? otw_o : 1'b1;
endmodule : afr_ctrl_model

// File: dv/tb_afr_fault_report.sv
`timescale 1ns/100ps
module tb_afr_fault_report import afr_pkg::*;;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic reset_n = 1'b0;
	logic gate_drive_supply = 1'b0;
	logic vdd_ok = 1'b0;
	logic [7:0] temp = 8'h19;
	logic olf = 1'b0;
	logic pwm_run = 1'b1;
	logic clk_en = 1'b1;
	logic sd_o, otw_o;
	logic [1:0] pwm_in;
	logic stage_enable, output_pulldown, sd_oe, otw_oe, sd_pin, otw_pin;
	logic [3:0] st;
	afr_fault_t fault_cause;
	int n_mismatch = 0;
	int tests_run = 0;
	always #25 clk = ~clk;
	assign st = {stage_enable, output_pulldown, sd_pin, otw_pin};
	afr_fault_report #(.PWM_IDLE(8)) DUT (.clk(clk), .srst(srst), .clk_en(clk_en),
		.reset_n(reset_n), .gate_drive_supply(gate_drive_supply), .vdd_supply_ok(vdd_ok),
		.junction_temp(temp), .overload_fault(olf), .pwm_in(pwm_in),
		.stage_enable(stage_enable), .output_pulldown(output_pulldown),
		.shutdown_flag_n_o(sd_o), .shutdown_flag_n_oe(sd_oe), .overtemp_warn_n_o(otw_o),
		.overtemp_warn_n_oe(otw_oe), .fault_cause(fault_cause));
	afr_ctrl_model ctrl (.clk(clk), .pwm_run(pwm_run), .sd_o(sd_o), .sd_oe(sd_oe),
		.otw_o(otw_o), .otw_oe(otw_oe),
		.pwm_in(pwm_in), .sd_pin(sd_pin), .otw_pin(otw_pin));
	// ****************
	// Helpers
	// ****************
	task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic go(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : go
	// Device reset pulse; reset_n goes low at the next edge, held four cycles, then released for three
	task automatic dev_reset();
		@(posedge clk) reset_n <= 1'b0;
		go(3);
		chk("reset_low", st, 4'h7);
		@(posedge clk) reset_n <= 1'b1;
		go(3);
	endtask : dev_reset
	task automatic complete_run();
		if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : complete_run
	// ****************
	// Tests
	// ****************
	initial begin
		go(20);
		@(posedge clk) srst <= 1'b0;
		go(3);
		chk("powerup", st, 4'h7);
		@(posedge clk) reset_n <= 1'b1;
		go(3);
		chk("uv", st, 4'h1);
		chk("uv_cause", fault_cause, 4'h8);
		@(posedge clk) gate_drive_supply <= 1'b1;
		go(3);
		chk("uv_vdd", st, 4'h1);
		@(posedge clk) vdd_ok <= 1'b1;
		go(3);
		chk("run", st, 4'hB);
		@(posedge clk) olf <= 1'b1;
		go(3);
		chk("ovl", st, 4'h1);
		chk("ovl_cause", fault_cause, 4'h4);
		@(posedge clk) olf <= 1'b0;
		go(6);
		chk("ovl_held", st, 4'h1);
		dev_reset();
		chk("ovl_back", st, 4'hB);
		@(posedge clk) temp <= 8'h74;
		go(3);
		chk("warn", st, 4'hA);
		@(posedge clk) temp <= 8'h19;
		go(3);
		chk("warn_clear", st, 4'hB);
		@(posedge clk) temp <= 8'h9B;
		go(3);
		chk("ote", st, 4'h0);
		chk("ote_cause", fault_cause, 4'h1);
		@(posedge clk) temp <= 8'h19;
		go(4);
		chk("ote_held", st, 4'h0);
		dev_reset();
		chk("ote_back", st, 4'hB);
		@(posedge clk) pwm_run <= 1'b0;
		go(9);
		chk("pwm_early", st, 4'hB);
		go(5);
		chk("pwm_idle", st, 4'h1);
		chk("pwm_cause", fault_cause, 4'h2);
		@(posedge clk) pwm_run <= 1'b1;
		go(3);
		chk("pwm_back", st, 4'hB);
		@(posedge clk) gate_drive_supply <= 1'b0;
		go(3);
		chk("brownout", st, 4'h1);
		@(posedge clk) gate_drive_supply <= 1'b1;
		go(3);
		chk("uv_back", st, 4'hB);
		@(posedge clk) clk_en <= 1'b0;
		olf <= 1'b1;
		go(3);
		chk("frozen", st, 4'hB);
		@(posedge clk) clk_en <= 1'b1;
		go(3);
		chk("unfrozen", st, 4'h1);
		@(posedge clk) olf <= 1'b0;
		dev_reset();
		chk("olp_back", st, 4'hB);
		@(posedge clk) vdd_ok <= 1'b0;
		go(3);
		chk("powerdown", st, 4'h1);
		@(posedge clk) reset_n <= 1'b0;
		go(3);
		chk("pd_reset", st, 4'h7);
		complete_run();
	end
	// Whole sequence needs about 130 cycles, well under the 2000-cycle limit below
	initial begin
		#(2000 * 50);
		n_mismatch++;
		complete_run();
	end
endmodule : tb_afr_fault_report
